/* hdfs_pkg.sv */
// Constants, register map and carrier types of the downstream port force and sense block.
package hdfs_pkg;

  localparam int HDFS_NUM_PORTS = 7;
  localparam int HDFS_CTL_PORTS = 4;
  localparam int HDFS_HI_PORTS = HDFS_NUM_PORTS - HDFS_CTL_PORTS;
  localparam int HDFS_REG_W = 8;
  localparam int HDFS_DATA_W = 32;
  localparam int HDFS_STRB_W = HDFS_DATA_W / 8;
  localparam int HDFS_ADDR_W = 12;
  localparam int HDFS_IDX_W = HDFS_ADDR_W - 2;

  // Register indices; the byte address is four times the index.
  localparam logic [HDFS_IDX_W-1:0] HDFS_IDX_SE0 = 10'h04f;
  localparam logic [HDFS_IDX_W-1:0] HDFS_IDX_DATA = 10'h050;
  localparam logic [HDFS_IDX_W-1:0] HDFS_IDX_FL_LO = 10'h051;
  localparam logic [HDFS_IDX_W-1:0] HDFS_IDX_FL_HI = 10'h052;
  localparam logic [HDFS_IDX_W-1:0] HDFS_IDX_CTL = 10'h053;

  localparam logic [HDFS_REG_W-1:0] HDFS_RST_REG = 8'h00;
  localparam logic [HDFS_NUM_PORTS-1:0] HDFS_RST_SENSE = 7'h00;
  localparam logic [2*HDFS_HI_PORTS-1:0] HDFS_RST_FL_HI = 6'h00;

  // Two-bit line control codes.
  localparam logic [1:0] HDFS_CTL_NONE = 2'h0;
  localparam logic [1:0] HDFS_CTL_DIFF1 = 2'h1;
  localparam logic [1:0] HDFS_CTL_DIFF0 = 2'h2;
  localparam logic [1:0] HDFS_CTL_SE0 = 2'h3;

  localparam logic [1:0] HDFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] HDFS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic dp_out;
    logic dp_oe_n;
    logic dm_out;
    logic dm_oe_n;
    logic edge_en;
    logic edge_ls;
  } hdfs_pin_s;

  localparam hdfs_pin_s HDFS_PIN_RST = '{dp_out: 1'b0, dp_oe_n: 1'b1, dm_out: 1'b0,
                                          dm_oe_n: 1'b1, edge_en: 1'b0, edge_ls: 1'b0};

  typedef struct packed {
    logic [1:0] resp;
    logic [HDFS_DATA_W-1:0] data;
  } hdfs_rd_s;

endpackage

/* hdfs_top.sv */
// Downstream port line forcing, pin force-low and line sensing with an AXI4-Lite slave.
//
// Overview of operation
// - Control register: two bits per port 1-4.
// - Code 00 leaves port unforced, normal repeating.
// - Code 01 drives plus high, minus low.
// - Code 10 drives plus low, minus high.
// - Force-low pins bypass edge-rate shaping on ports with control code 00 and on all ports during suspend.
// - Each force-low bit pulls one pin low.
// - Force-low keeps holding pins during suspend.
// - Both force-low bits give single-ended zero.
// - First force-low register maps ports 1-4.
// - Second force-low register maps ports 5-7.
// - Data register reports differential state only.
// - During SE0, data bit keeps last value.
// - Chip and bus reset clear sense registers.
// - SE0 status bit per port, bit 7 zero.
// - Control register survives bus reset only.
// - Control forcing uses port speed edge rate.
module hdfs_top
  import hdfs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic USB_BUS_RST,
  input wire logic SUSPEND,
  input wire logic [HDFS_NUM_PORTS-1:0] PORT_LOW_SPEED,
  input wire logic [HDFS_NUM_PORTS-1:0] PORT_DP_IN,
  input wire logic [HDFS_NUM_PORTS-1:0] PORT_DM_IN,
  output logic [HDFS_NUM_PORTS-1:0] PORT_DP_OUT,
  output logic [HDFS_NUM_PORTS-1:0] PORT_DP_OE_N,
  output logic [HDFS_NUM_PORTS-1:0] PORT_DM_OUT,
  output logic [HDFS_NUM_PORTS-1:0] PORT_DM_OE_N,
  output logic [HDFS_NUM_PORTS-1:0] PORT_EDGE_EN,
  output logic [HDFS_NUM_PORTS-1:0] PORT_EDGE_LS,
  input wire logic [HDFS_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [HDFS_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [HDFS_STRB_W-1:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [HDFS_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [HDFS_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  logic [HDFS_REG_W-1:0] ctl_reg;
  logic [HDFS_REG_W-1:0] fl_lo;
  logic [2*HDFS_HI_PORTS-1:0] fl_hi;
  logic [HDFS_NUM_PORTS-1:0] dp_s1;
  logic [HDFS_NUM_PORTS-1:0] dp_s2;
  logic [HDFS_NUM_PORTS-1:0] dm_s1;
  logic [HDFS_NUM_PORTS-1:0] dm_s2;
  logic [HDFS_NUM_PORTS-1:0] se0_stat;
  logic [HDFS_NUM_PORTS-1:0] diff_data;
  logic [HDFS_NUM_PORTS-1:0] is_diff;
  logic [2*HDFS_NUM_PORTS-1:0] ctl_all;
  logic [2*HDFS_NUM_PORTS-1:0] fl_all;
  logic [HDFS_ADDR_W-1:0] aw_addr;
  logic [HDFS_DATA_W-1:0] w_data;
  logic [HDFS_STRB_W-1:0] w_strb;
  logic do_write;
  logic aw_hit_ctl;
  logic aw_hit_lo;
  logic aw_hit_hi;
  logic aw_mapped;
  hdfs_rd_s rd_lookup;
  hdfs_pin_s pin_q [HDFS_NUM_PORTS];

  // Write address and data are held until both are in; the write then runs once.
  assign do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign aw_hit_ctl = aw_addr[HDFS_ADDR_W-1:2] == HDFS_IDX_CTL;
  assign aw_hit_lo = aw_addr[HDFS_ADDR_W-1:2] == HDFS_IDX_FL_LO;
  assign aw_hit_hi = aw_addr[HDFS_ADDR_W-1:2] == HDFS_IDX_FL_HI;
  assign aw_mapped = aw_hit_ctl || aw_hit_lo || aw_hit_hi ||
                     aw_addr[HDFS_ADDR_W-1:2] == HDFS_IDX_SE0 ||
                     aw_addr[HDFS_ADDR_W-1:2] == HDFS_IDX_DATA;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_AWREADY <= 1'b1;
      aw_addr <= '0;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      S_AXI_AWREADY <= 1'b0;
      aw_addr <= S_AXI_AWADDR;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_WREADY <= 1'b1;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      S_AXI_WREADY <= 1'b0;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= HDFS_RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= aw_mapped ? HDFS_RESP_OKAY : HDFS_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // The control field is cleared only by chip reset, never by bus reset.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctl_reg <= HDFS_RST_REG;
    end
    else if (do_write && aw_hit_ctl && w_strb[0])
    begin
      ctl_reg <= w_data[HDFS_REG_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      fl_lo <= HDFS_RST_REG;
      fl_hi <= HDFS_RST_FL_HI;
    end
    else if (do_write && w_strb[0])
    begin
      if (aw_hit_lo)
      begin
        fl_lo <= w_data[HDFS_REG_W-1:0];
      end
      else if (aw_hit_hi)
      begin
        fl_hi <= w_data[2*HDFS_HI_PORTS-1:0];
      end
    end
  end

  always_comb
  begin
    rd_lookup.resp = HDFS_RESP_OKAY;
    rd_lookup.data = '0;
    if (S_AXI_ARADDR[HDFS_ADDR_W-1:2] == HDFS_IDX_SE0)
    begin
      rd_lookup.data[HDFS_NUM_PORTS-1:0] = se0_stat;
    end
    else if (S_AXI_ARADDR[HDFS_ADDR_W-1:2] == HDFS_IDX_DATA)
    begin
      rd_lookup.data[HDFS_NUM_PORTS-1:0] = diff_data;
    end
    else if (S_AXI_ARADDR[HDFS_ADDR_W-1:2] == HDFS_IDX_FL_LO)
    begin
      rd_lookup.data[HDFS_REG_W-1:0] = fl_lo;
    end
    else if (S_AXI_ARADDR[HDFS_ADDR_W-1:2] == HDFS_IDX_FL_HI)
    begin
      rd_lookup.data[2*HDFS_HI_PORTS-1:0] = fl_hi;
    end
    else if (S_AXI_ARADDR[HDFS_ADDR_W-1:2] == HDFS_IDX_CTL)
    begin
      rd_lookup.data[HDFS_REG_W-1:0] = ctl_reg;
    end
    else
    begin
      rd_lookup.resp = HDFS_RESP_SLVERR;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= HDFS_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_lookup.data;
      S_AXI_RRESP <= rd_lookup.resp;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Pads are asynchronous to the core; only the second stage feeds the sense logic.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      dp_s1 <= HDFS_RST_SENSE;
      dp_s2 <= HDFS_RST_SENSE;
      dm_s1 <= HDFS_RST_SENSE;
      dm_s2 <= HDFS_RST_SENSE;
    end
    else
    begin
      dp_s1 <= PORT_DP_IN;
      dm_s1 <= PORT_DM_IN;
      dp_s2 <= dp_s1;
      dm_s2 <= dm_s1;
    end
  end

  // A single-ended one is neither SE0 nor differential, so it also holds the data bit.
  assign is_diff = dp_s2 ^ dm_s2;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      se0_stat <= HDFS_RST_SENSE;
      diff_data <= HDFS_RST_SENSE;
    end
    else if (USB_BUS_RST)
    begin
      se0_stat <= HDFS_RST_SENSE;
      diff_data <= HDFS_RST_SENSE;
    end
    else
    begin
      se0_stat <= ~dp_s2 & ~dm_s2;
      diff_data <= (diff_data & ~is_diff) | (dp_s2 & is_diff);
    end
  end

  assign ctl_all = {{(2*HDFS_HI_PORTS){1'b0}}, ctl_reg};
  assign fl_all = {fl_hi, fl_lo};

  genvar g;
  generate
    for (g = 0; g < HDFS_NUM_PORTS; g++)
    begin : g_port
      logic [1:0] fld;
      logic fl_dp;
      logic fl_dm;
      hdfs_pin_s next_pin;
      // Edge-rate forcing is dropped in suspend; the raw force-low pins keep holding.
      assign fld = SUSPEND ? HDFS_CTL_NONE : ctl_all[2*g+1:2*g];
      assign fl_dp = fl_all[2*g+1];
      assign fl_dm = fl_all[2*g];
      always_comb
      begin
        next_pin.dp_oe_n = !(fld != HDFS_CTL_NONE || fl_dp);
        next_pin.dm_oe_n = !(fld != HDFS_CTL_NONE || fl_dm);
        next_pin.dp_out = fld == HDFS_CTL_DIFF1 && !fl_dp;
        next_pin.dm_out = fld == HDFS_CTL_DIFF0 && !fl_dm;
        next_pin.edge_en = fld != HDFS_CTL_NONE;
        next_pin.edge_ls = PORT_LOW_SPEED[g];
      end
      always_ff @(posedge REF_CLK or posedge SYS_RST)
      begin
        if (SYS_RST)
        begin
          pin_q[g] <= HDFS_PIN_RST;
        end
        else
        begin
          pin_q[g] <= next_pin;
        end
      end
      assign PORT_DP_OUT[g] = pin_q[g].dp_out;
      assign PORT_DP_OE_N[g] = pin_q[g].dp_oe_n;
      assign PORT_DM_OUT[g] = pin_q[g].dm_out;
      assign PORT_DM_OE_N[g] = pin_q[g].dm_oe_n;
      assign PORT_EDGE_EN[g] = pin_q[g].edge_en;
      assign PORT_EDGE_LS[g] = pin_q[g].edge_ls;
      sequence s_free;
        !SUSPEND && !fl_dp && !fl_dm;
      endsequence
      sequence s_line_se0;
        !PORT_DP_IN[g] && !PORT_DM_IN[g];
      endsequence
      AST_IDLE_RELEASE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        s_free ##0 fld == HDFS_CTL_NONE |=> PORT_DP_OE_N[g] && PORT_DM_OE_N[g] && !PORT_EDGE_EN[g])
        else $error("Unforced port still driven.");
      AST_DIFF_ONE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        s_free ##0 ctl_all[2*g+1:2*g] == HDFS_CTL_DIFF1
        |=> PORT_DP_OUT[g] && !PORT_DM_OUT[g] && !PORT_DP_OE_N[g] && !PORT_DM_OE_N[g])
        else $error("Differential one not driven.");
      AST_DIFF_ZERO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        s_free ##0 ctl_all[2*g+1:2*g] == HDFS_CTL_DIFF0
        |=> !PORT_DP_OUT[g] && PORT_DM_OUT[g] && !PORT_DP_OE_N[g] && !PORT_DM_OE_N[g])
        else $error("Differential zero not driven.");
      AST_CTL_SE0: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        s_free ##0 ctl_all[2*g+1:2*g] == HDFS_CTL_SE0
        |=> !PORT_DP_OUT[g] && !PORT_DM_OUT[g] && !PORT_DP_OE_N[g] && PORT_EDGE_EN[g])
        else $error("Control SE0 not driven.");
      AST_FORCE_LOW: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        fl_dp && fl_dm |=> !PORT_DP_OUT[g] && !PORT_DM_OUT[g] &&
                           !PORT_DP_OE_N[g] && !PORT_DM_OE_N[g])
        else $error("Force-low pair not holding SE0.");
      AST_RAW_EDGE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        SUSPEND || fld == HDFS_CTL_NONE |=> !PORT_EDGE_EN[g])
        else $error("Edge shaping active without control forcing.");
      AST_SE0_SENSE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        s_line_se0 ##2 !USB_BUS_RST |=> se0_stat[g])
        else $error("Line SE0 not reported three cycles later.");
      AST_DATA_HOLD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !dp_s2[g] && !dm_s2[g] && !USB_BUS_RST |=> $stable(diff_data[g]))
        else $error("Data bit changed during SE0.");
    end
  endgenerate
  AST_BUS_RST_CLEAR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    USB_BUS_RST |=> se0_stat == HDFS_RST_SENSE && diff_data == HDFS_RST_SENSE)
    else $error("Sense registers not cleared by bus reset.");
  AST_CTL_KEEP: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    USB_BUS_RST && !do_write |=> $stable(ctl_reg))
    else $error("Control register disturbed by bus reset.");
  AST_RSV_ZERO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    S_AXI_RVALID && $past(S_AXI_ARADDR[HDFS_ADDR_W-1:2]) == HDFS_IDX_FL_HI && $rose(S_AXI_RVALID)
    |-> S_AXI_RDATA[HDFS_DATA_W-1:2*HDFS_HI_PORTS] == '0)
    else $error("Reserved force-low bits read non-zero.");
  AST_BRESP_HOLD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped before acceptance.");
endmodule // hdfs_top

/* hdfs_usb_dev.sv */
// Model of the devices attached to the downstream ports, resolving each data line.
module hdfs_usb_dev
  import hdfs_pkg::*;
(
  input wire logic [HDFS_NUM_PORTS-1:0] hub_dp,
  input wire logic [HDFS_NUM_PORTS-1:0] hub_dp_oe_n,
  input wire logic [HDFS_NUM_PORTS-1:0] hub_dm,
  input wire logic [HDFS_NUM_PORTS-1:0] hub_dm_oe_n,
  input wire logic [HDFS_NUM_PORTS-1:0] dev_dp,
  input wire logic [HDFS_NUM_PORTS-1:0] dev_dm,
  output logic [HDFS_NUM_PORTS-1:0] line_dp,
  output logic [HDFS_NUM_PORTS-1:0] line_dm
);
  timeunit 1ns;
  timeprecision 100ps;
  // A driven hub pin beats the device's pull, so a forced level is what the sensor sees.
  assign line_dp = (hub_dp & ~hub_dp_oe_n) | (dev_dp & hub_dp_oe_n);
  assign line_dm = (hub_dm & ~hub_dm_oe_n) | (dev_dm & hub_dm_oe_n);
endmodule // hdfs_usb_dev

/* tb_hub_downstream_port_force_sense.sv */
// Self-checking bench for the downstream port force and sense block.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_hub_downstream_port_force_sense
  import hdfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, sys_rst, bus_rst, suspend;
  logic [6:0] low_spd, dev_dp, dev_dm, dp_in, dm_in, dp_out, dp_oe_n, dm_out, dm_oe_n;
  logic [6:0] edge_en, edge_ls, exp_d;
  logic [HDFS_ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, code;
  int n_fail = 0;
  int num_checks = 0;
  hdfs_top u_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .USB_BUS_RST(bus_rst),
    .SUSPEND(suspend), .PORT_LOW_SPEED(low_spd), .PORT_DP_IN(dp_in), .PORT_DM_IN(dm_in),
    .PORT_DP_OUT(dp_out), .PORT_DP_OE_N(dp_oe_n), .PORT_DM_OUT(dm_out),
    .PORT_DM_OE_N(dm_oe_n), .PORT_EDGE_EN(edge_en), .PORT_EDGE_LS(edge_ls),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  hdfs_usb_dev u_dev (.hub_dp(dp_out), .hub_dp_oe_n(dp_oe_n), .hub_dm(dm_out),
    .hub_dm_oe_n(dm_oe_n), .dev_dp(dev_dp), .dev_dm(dev_dm), .line_dp(dp_in), .line_dm(dm_in));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(n, 3)
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(n, 2)
    `CHK(rdata, {24'h000000, e})
    `CHK(rresp, er)
  endtask
  // Driven levels are compared only where the pin is enabled; a released pin's level is free.
  task automatic pins(input logic [6:0] dpv, dpo, dmv, dmo, en);
    // Looked at on the third edge, so the levels seen are those launched by the second.
    repeat (3) @(posedge ref_clk);
    `CHK(dp_out & ~dp_oe_n, dpv)
    `CHK(dp_oe_n, dpo)
    `CHK(dm_out & ~dm_oe_n, dmv)
    `CHK(dm_oe_n, dmo)
    `CHK(edge_en, en)
  endtask
  task automatic settle();
    repeat (5) @(posedge ref_clk);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    {sys_rst, bus_rst, suspend, low_spd, dev_dp, dev_dm} = {3'h6, 7'h05, 7'h7f, 7'h00};
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(HDFS_IDX_SE0, 8'h00, HDFS_RESP_OKAY);
    rd(HDFS_IDX_DATA, 8'h00, HDFS_RESP_OKAY);
    rd(HDFS_IDX_FL_LO, 8'h00, HDFS_RESP_OKAY);
    rd(HDFS_IDX_FL_HI, 8'h00, HDFS_RESP_OKAY);
    rd(HDFS_IDX_CTL, 8'h00, HDFS_RESP_OKAY);
    rd(10'h060, 8'h00, HDFS_RESP_SLVERR);
    pins(7'h00, 7'h7f, 7'h00, 7'h7f, 7'h00);
    `CHK(edge_ls, low_spd)
    bus_rst <= 1'b0;
    settle();
    rd(HDFS_IDX_DATA, 8'h7f, HDFS_RESP_OKAY);
    rd(HDFS_IDX_SE0, 8'h00, HDFS_RESP_OKAY);
    $display("test reset done");
    exp_d = 7'h7f;
    for (int c = 0; c < 4; c++)
    begin
      code = c[1:0];
      wr(HDFS_IDX_CTL, {4{code}}, HDFS_RESP_OKAY);
      pins({3'h0, {4{code == 2'h1}}}, {3'h7, {4{code == 2'h0}}}, {3'h0, {4{code == 2'h2}}},
        {3'h7, {4{code == 2'h0}}}, {3'h0, {4{code != 2'h0}}});
      if (code != 2'h3)
        exp_d[3:0] = {4{code != 2'h2}};
      settle();
      rd(HDFS_IDX_CTL, {4{code}}, HDFS_RESP_OKAY);
      rd(HDFS_IDX_SE0, {4'h0, {4{code == 2'h3}}}, HDFS_RESP_OKAY);
      rd(HDFS_IDX_DATA, {1'b0, exp_d}, HDFS_RESP_OKAY);
    end
    $display("test control codes done");
    wr(HDFS_IDX_CTL, 8'h55, HDFS_RESP_OKAY);
    settle();
    wr(HDFS_IDX_FL_HI, 8'hff, HDFS_RESP_OKAY);
    wr(HDFS_IDX_FL_LO, 8'h02, HDFS_RESP_OKAY);
    pins(7'h0e, 7'h00, 7'h00, 7'h00, 7'h0f);
    rd(HDFS_IDX_FL_HI, 8'h3f, HDFS_RESP_OKAY);
    settle();
    rd(HDFS_IDX_SE0, 8'h71, HDFS_RESP_OKAY);
    rd(HDFS_IDX_DATA, 8'h7f, HDFS_RESP_OKAY);
    suspend <= 1'b1;
    pins(7'h00, 7'h0e, 7'h00, 7'h0f, 7'h00);
    suspend <= 1'b0;
    $display("test force low done");
    wr(HDFS_IDX_SE0, 8'hff, HDFS_RESP_OKAY);
    rd(HDFS_IDX_SE0, 8'h71, HDFS_RESP_OKAY);
    wr(10'h060, 8'hff, HDFS_RESP_SLVERR);
    bus_rst <= 1'b1;
    rd(HDFS_IDX_SE0, 8'h00, HDFS_RESP_OKAY);
    rd(HDFS_IDX_DATA, 8'h00, HDFS_RESP_OKAY);
    rd(HDFS_IDX_CTL, 8'h55, HDFS_RESP_OKAY);
    rd(HDFS_IDX_FL_LO, 8'h02, HDFS_RESP_OKAY);
    bus_rst <= 1'b0;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(HDFS_IDX_CTL, 8'h00, HDFS_RESP_OKAY);
    rd(HDFS_IDX_FL_HI, 8'h00, HDFS_RESP_OKAY);
    pins(7'h00, 7'h7f, 7'h00, 7'h7f, 7'h00);
    $display("test resets done");
    tally_and_finish();
  end
endmodule // tb_hub_downstream_port_force_sense
